// ==== i2cm_bus_model.sv ====
// far side of the two-wire bus: pull-ups, other masters and slaves
// assumes the bench tells it when to hold a line low
`timescale 1ns/100ps
`default_nettype none

module i2cm_bus_model
  import i2cm_pkg::*;
(
  input  wire logic                  pclk,    // bench clock
  input  wire logic                  presetn, // async reset, low
  input  wire i2cm_pkg::i2cm_lines_t dut_out, // device drive level
  input  wire i2cm_pkg::i2cm_lines_t dut_oe,  // device pulls line
  input  wire i2cm_pkg::i2cm_lines_t pull,    // other party pulls
  input  wire logic [7:0]            stretch, // slave clock hold
  output i2cm_pkg::i2cm_lines_t      lines    // resolved wire
);
  logic [7:0] hold_reg;
  logic       oe_reg;
  logic       held;

  // a slow slave keeps the clock low for a while after release
  assign held = (oe_reg && !dut_oe.scl && stretch != 8'h00) ||
                hold_reg != 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_reg   <= 1'b0;
      hold_reg <= 8'h00;
    end else begin
      oe_reg <= dut_oe.scl;
      if (oe_reg && !dut_oe.scl)
        hold_reg <= stretch;
      else if (hold_reg != 8'h00)
        hold_reg <= hold_reg - 8'h01;
    end
  end

  // pull-ups: a released line reads high
  assign lines.scl = !(pull.scl || held) && (dut_oe.scl ? dut_out.scl : 1'b1);
  assign lines.sda = !pull.sda && (dut_oe.sda ? dut_out.sda : 1'b1);
endmodule

`default_nettype wire

// ==== i2cm_core.sv ====
// two-wire master: repeated start / stop collision checks, byte shift
// and the reload rate counter, with an apb register slave
// assumes open-drain lines resolved outside; pins are asynchronous
// Operation
// - repeated start: data low when clock rises is a collision.
// - repeated start: clock falling before data is driven low is a collision.
// - release data, count reload to zero, release clock, sample data high.
// - data high: reload and count again; early data fall is no collision.
// - second count: clock falling before expiry, data undriven, is a collision.
// - both high at expiry: drive data low, count, then drive clock low.
// - stop: hold data low, release clock, then count reload down to zero.
// - stop: data sampled low after release and expiry is a collision.
// - stop: clock sampled low before data rose is a collision.
// - master clock timed by down counter loaded from software reload value.
// - writing the transmit buffer starts the rate counter.
// - operation end stops the counter, clock pin keeps its level.
// - counter reloads twice per bus clock period.
// - reload 13h, 0Bh, 04h give 100, 166, 400 kHz at a 16 MHz input clock.
// - collision flag and enable at bit 5, port event at bit 4.
// - any collision sets the collision flag and returns the port idle.
// - aborted sequence releases both lines and clears its request bits.
`timescale 1ns/100ps
`default_nettype none
`include "i2cm_defines.svh"

module i2cm_core (
  input  wire logic                 pclk,      // 40 mhz clock
  input  wire logic                 presetn,   // async reset, low
  input  wire logic                 psel,      // apb select
  input  wire logic                 penable,   // apb access phase
  input  wire logic                 pwrite,    // apb write
  input  wire logic [7:0]           paddr,     // apb byte address
  input  wire logic [31:0]          pwdata,    // apb write data
  output logic      [31:0]          prdata,    // apb read data
  output logic                      pready,    // apb ready
  output logic                      pslverr,   // unmapped address
  input  wire i2cm_pkg::i2cm_lines_t lines_in, // line levels
  output i2cm_pkg::i2cm_lines_t     lines_out, // driven level, always 0
  output i2cm_pkg::i2cm_lines_t     lines_oe,  // high pulls line low
  output logic                      irq        // level interrupt
);
  import i2cm_pkg::*;

  i2cm_state_t state_reg;
  logic [7:0]  enable_reg;
  logic [7:0]  flags_reg;
  logic [7:0]  reload_reg;
  logic [7:0]  buffer_reg;
  logic [7:0]  ctl2_reg;
  logic [7:0]  cnt_reg;
  logic [7:0]  shift_reg;
  logic [3:0]  bit_reg;
  logic        half_reg;
  logic        run_reg;
  logic [1:0]  div_reg;
  logic        tick_reg;
  logic        col_set_reg;
  logic        ev_set_reg;
  logic [2:0]  scl_sync_reg;
  logic [2:0]  sda_sync_reg;
  logic        scl_f_reg;
  logic        sda_f_reg;
  logic [7:0]  rd_clr_reg;
  logic        access;
  logic        wr_acc;
  logic        rd_flags;
  logic        buf_wr;
  logic        ctl2_wr;
  logic        tmo;
  logic        abort;
  logic [7:0]  flags_next;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `I2CM_OFF_IRQ_ENABLE) || (a == `I2CM_OFF_IRQ_FLAGS) ||
             (a == `I2CM_OFF_RELOAD) || (a == `I2CM_OFF_BUFFER) ||
             (a == `I2CM_OFF_CONTROL_TWO);
  endfunction

  function automatic logic [7:0] rd_mux(input logic [7:0] a,
                                        input logic [7:0] en,
                                        input logic [7:0] fl,
                                        input logic [7:0] rl,
                                        input logic [7:0] bf,
                                        input logic [7:0] c2);
    case (a)
      `I2CM_OFF_IRQ_ENABLE:  rd_mux = en;
      `I2CM_OFF_IRQ_FLAGS:   rd_mux = fl;
      `I2CM_OFF_RELOAD:      rd_mux = rl;
      `I2CM_OFF_BUFFER:      rd_mux = bf;
      `I2CM_OFF_CONTROL_TWO: rd_mux = c2;
      default:               rd_mux = 8'h00;
    endcase
  endfunction

  // one wait-free access phase: pready is raised from the setup cycle
  assign access   = psel && penable && pready;
  assign wr_acc   = access && pwrite && !pslverr;
  assign rd_flags = access && !pwrite && (paddr == `I2CM_OFF_IRQ_FLAGS);
  assign buf_wr   = wr_acc && (paddr == `I2CM_OFF_BUFFER);
  assign ctl2_wr  = wr_acc && (paddr == `I2CM_OFF_CONTROL_TWO);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped(paddr);
      if (psel && !penable && !pwrite) begin
        prdata <= {24'h00_0000, rd_mux(paddr, enable_reg, flags_reg,
                                       reload_reg, buffer_reg, ctl2_reg)};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_reg <= `I2CM_RST_REG8;
      reload_reg <= `I2CM_RST_RELOAD;
      buffer_reg <= `I2CM_RST_REG8;
    end else if (wr_acc) begin
      case (paddr)
        `I2CM_OFF_IRQ_ENABLE: begin
          enable_reg <= pwdata[7:0] &
                        8'h30;
        end
        `I2CM_OFF_RELOAD: begin
          reload_reg <= pwdata[7:0];
        end
        `I2CM_OFF_BUFFER: begin
          if (state_reg == I2CM_IDLE) begin
            buffer_reg <= pwdata[7:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // only bits actually returned by the read are cleared, so a set that
  // lands between setup and access is not lost; set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_clr_reg <= `I2CM_RST_REG8;
    end else if (psel && !penable) begin
      rd_clr_reg <= flags_reg;
    end
  end

  always_comb begin
    flags_next = flags_reg;
    if (rd_flags) begin
      flags_next = flags_next & ~rd_clr_reg;
    end
    if (col_set_reg) begin
      flags_next[`I2CM_BIT_COLLISION] = 1'b1;
    end
    if (ev_set_reg) begin
      flags_next[`I2CM_BIT_PORT_EVENT] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg <= `I2CM_RST_REG8;
      irq       <= 1'b0;
    end else begin
      flags_reg <= flags_next;
      irq       <= |(flags_next & enable_reg);
    end
  end

  // three-stage filter: level accepted only when stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      scl_f_reg    <= 1'b1;
      sda_f_reg    <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], lines_in.scl};
      sda_sync_reg <= {sda_sync_reg[1:0], lines_in.sda};
      if (scl_sync_reg[1] == scl_sync_reg[2]) begin
        scl_f_reg <= scl_sync_reg[2];
      end
      if (sda_sync_reg[1] == sda_sync_reg[2]) begin
        sda_f_reg <= sda_sync_reg[2];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg  <= 2'h0;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (div_reg == `I2CM_INSTR_DIV);
      div_reg  <= div_reg + 2'h1;
    end
  end

  assign tmo = run_reg && tick_reg && (cnt_reg == 8'h00);

  always_comb begin
    case (state_reg)
      I2CM_RS_SCLH: abort = scl_f_reg && !sda_f_reg;
      I2CM_RS_CNT2: abort = !scl_f_reg && !lines_oe.sda;
      I2CM_P_CNT:   abort = !scl_f_reg;
      I2CM_P_SDAR:  abort = (tmo && !sda_f_reg) ||
                            (!scl_f_reg && !sda_f_reg);
      I2CM_TX:      abort = half_reg && scl_f_reg && !lines_oe.sda &&
                            !sda_f_reg && (bit_reg != `I2CM_LAST_BIT);
      default:      abort = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg   <= I2CM_IDLE;
      ctl2_reg    <= `I2CM_RST_REG8;
      cnt_reg     <= 8'h00;
      run_reg     <= 1'b0;
      shift_reg   <= 8'h00;
      bit_reg     <= 4'h0;
      half_reg    <= 1'b0;
      lines_oe    <= '0;
      col_set_reg <= 1'b0;
      ev_set_reg  <= 1'b0;
    end else begin
      col_set_reg <= 1'b0;
      ev_set_reg  <= 1'b0;
      if (ctl2_wr) begin
        ctl2_reg <= pwdata[7:0];
      end
      if (run_reg && tick_reg && (cnt_reg != 8'h00)) begin
        cnt_reg <= cnt_reg - 8'h01;
      end
      if (abort) begin
        state_reg   <= I2CM_IDLE;
        lines_oe    <= '0;
        run_reg     <= 1'b0;
        col_set_reg <= 1'b1;
        ctl2_reg[`I2CM_BIT_START]   <= 1'b0;
        ctl2_reg[`I2CM_BIT_RESTART] <= 1'b0;
        ctl2_reg[`I2CM_BIT_STOP]    <= 1'b0;
        ctl2_reg[`I2CM_BIT_ACK_SEQ] <= 1'b0;
      end else begin
        case (state_reg)
          I2CM_IDLE: begin
            run_reg <= 1'b0;
            if (ctl2_reg[`I2CM_BIT_RESTART]) begin
              lines_oe.sda <= 1'b0;
              cnt_reg      <= reload_reg;
              run_reg      <= 1'b1;
              state_reg    <= I2CM_RS_REL;
            end else if (ctl2_reg[`I2CM_BIT_STOP]) begin
              lines_oe.sda <= 1'b1;
              state_reg    <= I2CM_P_SDAL;
            end else if (buf_wr) begin
              shift_reg    <= pwdata[7:0];
              bit_reg      <= 4'h0;
              half_reg     <= 1'b0;
              lines_oe.sda <= !pwdata[7];
              // clock pulled low first, so even a byte right after reset
              // gets a full low half before its first rising edge
              lines_oe.scl <= 1'b1;
              cnt_reg      <= reload_reg;
              run_reg      <= 1'b1;
              state_reg    <= I2CM_TX;
            end
          end
          I2CM_RS_REL: begin
            if (tmo) begin
              lines_oe.scl <= 1'b0;
              run_reg      <= 1'b0;
              state_reg    <= I2CM_RS_SCLH;
            end
          end
          I2CM_RS_SCLH: begin
            if (scl_f_reg) begin
              cnt_reg   <= reload_reg;
              run_reg   <= 1'b1;
              state_reg <= I2CM_RS_CNT2;
            end
          end
          I2CM_RS_CNT2: begin
            // a data fall here is another master's start, not a loss
            if (tmo) begin
              lines_oe.sda <= 1'b1;
              cnt_reg      <= reload_reg;
              state_reg    <= I2CM_RS_SDAL;
            end
          end
          I2CM_RS_SDAL: begin
            if (tmo) begin
              lines_oe.scl <= 1'b1;
              run_reg      <= 1'b0;
              ev_set_reg   <= 1'b1;
              ctl2_reg[`I2CM_BIT_RESTART] <= 1'b0;
              state_reg    <= I2CM_IDLE;
            end
          end
          I2CM_P_SDAL: begin
            if (!sda_f_reg) begin
              lines_oe.scl <= 1'b0;
              state_reg    <= I2CM_P_SCLH;
            end
          end
          I2CM_P_SCLH: begin
            if (scl_f_reg) begin
              cnt_reg   <= reload_reg;
              run_reg   <= 1'b1;
              state_reg <= I2CM_P_CNT;
            end
          end
          I2CM_P_CNT: begin
            if (tmo) begin
              lines_oe.sda <= 1'b0;
              cnt_reg      <= reload_reg;
              state_reg    <= I2CM_P_SDAR;
            end
          end
          I2CM_P_SDAR: begin
            if (tmo) begin
              run_reg    <= 1'b0;
              ev_set_reg <= 1'b1;
              ctl2_reg[`I2CM_BIT_STOP] <= 1'b0;
              state_reg  <= I2CM_IDLE;
            end
          end
          I2CM_TX: begin
            // two reloads per bus clock: one low half, one high half
            if (tmo && !half_reg) begin
              lines_oe.scl <= 1'b0;
              half_reg     <= 1'b1;
              cnt_reg      <= reload_reg;
            end else if (tmo) begin
              lines_oe.scl <= 1'b1;
              half_reg     <= 1'b0;
              cnt_reg      <= reload_reg;
              if (bit_reg == `I2CM_LAST_BIT) begin
                lines_oe.sda <= 1'b0;
                run_reg      <= 1'b0;
                ev_set_reg   <= 1'b1;
                state_reg    <= I2CM_IDLE;
              end else begin
                bit_reg      <= bit_reg + 4'h1;
                shift_reg    <= {shift_reg[6:0], 1'b0};
                lines_oe.sda <= (bit_reg == 4'h7) ? 1'b0 : !shift_reg[6];
              end
            end
          end
          default: begin
            state_reg <= I2CM_IDLE;
          end
        endcase
      end
    end
  end

  assign lines_out = '0;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_rs_clock_up;
    state_reg == I2CM_RS_SCLH && scl_f_reg;
  endsequence
  sequence s_idle_again;
    state_reg == I2CM_IDLE && !lines_oe.scl && !lines_oe.sda;
  endsequence

  property p_rs_data_low;
    s_rs_clock_up ##0 !sda_f_reg |=> s_idle_again ##1 flags_reg[5];
  endproperty
  a_rs_data_low: assert property (p_rs_data_low)
    else $error("restart data low not flagged");

  property p_rs_clock_fall;
    state_reg == I2CM_RS_CNT2 && !scl_f_reg |=> state_reg == I2CM_IDLE;
  endproperty
  a_rs_clock_fall: assert property (p_rs_clock_fall)
    else $error("restart clock fall not aborted");

  property p_rs_reload;
    s_rs_clock_up ##0 sda_f_reg |=> state_reg == I2CM_RS_CNT2 &&
                                   cnt_reg == $past(reload_reg) && run_reg;
  endproperty
  a_rs_reload: assert property (p_rs_reload)
    else $error("restart count not reloaded");

  property p_rs_finish;
    state_reg == I2CM_RS_SDAL && tmo |=> lines_oe.scl && lines_oe.sda &&
                                        state_reg == I2CM_IDLE ##1 !run_reg;
  endproperty
  a_rs_finish: assert property (p_rs_finish)
    else $error("restart did not pull clock low");

  property p_stop_count;
    state_reg == I2CM_P_SCLH && scl_f_reg |=> cnt_reg == $past(reload_reg)
                                             && run_reg && lines_oe.sda;
  endproperty
  a_stop_count: assert property (p_stop_count)
    else $error("stop count not loaded");

  property p_stop_data_low;
    state_reg == I2CM_P_SDAR && tmo && !sda_f_reg |=> col_set_reg;
  endproperty
  a_stop_data_low: assert property (p_stop_data_low)
    else $error("stop data low not flagged");

  property p_stop_clock_low;
    state_reg == I2CM_P_CNT && !scl_f_reg |=> col_set_reg ##1 flags_reg[5];
  endproperty
  a_stop_clock_low: assert property (p_stop_clock_low)
    else $error("stop clock low not flagged");

  property p_abort_clears;
    abort |=> (ctl2_reg[2:0] == 3'h0 && !ctl2_reg[4]) and s_idle_again;
  endproperty
  a_abort_clears: assert property (p_abort_clears)
    else $error("abort left requests or lines");

  property p_tick_rate;
    tick_reg |=> !tick_reg [*3] ##1 tick_reg;
  endproperty
  a_tick_rate: assert property (p_tick_rate)
    else $error("instruction tick rate wrong");

  property p_buffer_start;
    buf_wr && state_reg == I2CM_IDLE && !abort &&
    ctl2_reg[2:1] == 2'h0 |=> run_reg && state_reg == I2CM_TX;
  endproperty
  a_buffer_start: assert property (p_buffer_start)
    else $error("buffer write did not start counter");

endmodule
`default_nettype wire

// ==== i2cm_defines.svh ====
// register offsets, field positions, reset values and timing counts
// assumes a 32-bit apb bus with byte addresses, one register per word
`ifndef I2CM_DEFINES_SVH
`define I2CM_DEFINES_SVH

`define I2CM_OFF_IRQ_ENABLE  8'h00
`define I2CM_OFF_IRQ_FLAGS   8'h04
`define I2CM_OFF_RELOAD      8'h08
`define I2CM_OFF_BUFFER      8'h0c
`define I2CM_OFF_CONTROL_TWO 8'h10

`define I2CM_BIT_COLLISION   5
`define I2CM_BIT_PORT_EVENT  4

`define I2CM_BIT_ACK_SEQ     4
`define I2CM_BIT_STOP        2
`define I2CM_BIT_RESTART     1
`define I2CM_BIT_START       0

`define I2CM_RST_REG8        8'h00
`define I2CM_RST_RELOAD      8'h13

// instruction cycle is four input clocks (oscillator divided by four)
`define I2CM_INSTR_DIV       2'h3
`define I2CM_LAST_BIT        4'h8

`endif

// ==== i2cm_pkg.sv ====
// types shared by the two-wire master collision and rate block
// assumes i2cm_defines.svh holds all numeric constants
package i2cm_pkg;

  typedef enum logic [3:0] {
    I2CM_IDLE    = 4'h0,
    I2CM_RS_REL  = 4'h1,
    I2CM_RS_SCLH = 4'h3,
    I2CM_RS_CNT2 = 4'h2,
    I2CM_RS_SDAL = 4'h6,
    I2CM_P_SDAL  = 4'h7,
    I2CM_P_SCLH  = 4'h5,
    I2CM_P_CNT   = 4'h4,
    I2CM_P_SDAR  = 4'hc,
    I2CM_TX      = 4'hd
  } i2cm_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } i2cm_lines_t;

endpackage

// ==== i2cm_tb_top.sv ====
// self-checking bench: apb register access, bus ops and collisions
// assumes i2cm_core and i2cm_bus_model; restarts start with clock low
`timescale 1ns/100ps
`default_nettype none
`include "i2cm_defines.svh"

module i2cm_tb_top;
  import i2cm_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr, stretch;
  logic [31:0] pwdata, prdata, d;
  logic        e, scl_q;
  logic [8:0]  sh;
  i2cm_lines_t lines, lines_out, lines_oe, pull;
  int          n_mismatch, comparisons, run, last_run, irq_cnt, dd;
  int          len [3];
  logic [7:0]  rl [3] = '{8'h04, 8'h0b, 8'h13};
  logic [7:0]  bt [3] = '{8'ha5, 8'h3c, 8'hc3};

  i2cm_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lines_in(lines), .lines_out(lines_out), .lines_oe(lines_oe),
    .irq(irq));
  i2cm_bus_model i_bus (.pclk(pclk), .presetn(presetn),
    .dut_out(lines_out), .dut_oe(lines_oe), .pull(pull),
    .stretch(stretch), .lines(lines));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // bits on clock rise, clock low-phase length, cycles with interrupt high
  always @(posedge pclk) begin
    scl_q <= lines.scl;
    if (lines.scl && !scl_q) sh <= {sh[7:0], lines.sda};
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
    if (lines_oe.scl) run <= run + 1;
    else begin
      if (run != 0) last_run <= run;
      run <= 0;
    end
  end

  task automatic final_report;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // no assumed latency: only the watchdog ends a hung access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    xfer(1'b0, a, 32'h0);
    chk(d, x);
  endtask

  // start an operation, wait for its flag, check flags, requests, lines
  task automatic op(input logic [7:0] a, input logic [7:0] v,
                    input logic [7:0] fl, input logic [1:0] oe,
                    input logic by_irq);
    int n = 0;
    int c0;
    c0 = irq_cnt;
    xfer(1'b1, a, {24'h0, v});
    if (by_irq) begin
      while (irq !== 1'b1 && n < 20000) begin
        @(posedge pclk);
        n++;
      end
      chk({31'h0, irq}, 32'h1);
      xfer(1'b0, `I2CM_OFF_IRQ_FLAGS, 32'h0);
    end else begin
      do begin
        xfer(1'b0, `I2CM_OFF_IRQ_FLAGS, 32'h0);
        n++;
      end while (d === 32'h0 && n < 5000);
      chk(irq_cnt, c0);
    end
    chk(d, {24'h0, fl});
    rd(`I2CM_OFF_CONTROL_TWO, 32'h0);
    chk({30'h0, lines_oe}, {30'h0, oe});
    chk({30'h0, lines_out}, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask

  task automatic rs(input logic [1:0] hold, input logic [1:0] late,
                    input logic [7:0] fl, input logic [1:0] oe);
    @(posedge pclk);
    pull <= 2'b10 | hold;
    fork
      op(`I2CM_OFF_CONTROL_TWO, 8'h02, fl, oe, 1'b1);
      begin
        repeat (60) @(posedge pclk);
        pull <= hold;
        repeat (10) @(posedge pclk);
        pull <= hold | late;
      end
    join
    @(posedge pclk);
    pull <= 2'b00;
  endtask

  initial begin
    repeat (40000) @(posedge pclk);
    n_mismatch++;
    final_report();
  end

  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    pull    = 2'b00;
    stretch = 8'h00;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(`I2CM_OFF_IRQ_ENABLE, 32'h0);
    rd(`I2CM_OFF_IRQ_FLAGS, 32'h0);
    rd(`I2CM_OFF_RELOAD, 32'h13);
    rd(`I2CM_OFF_CONTROL_TWO, 32'h0);
    rd(8'h14, 32'h0);
    chk({31'h0, e}, 32'h1);
    xfer(1'b1, 8'h14, 32'hff);
    chk({31'h0, e}, 32'h1);
    xfer(1'b1, `I2CM_OFF_IRQ_ENABLE, 32'hff);
    rd(`I2CM_OFF_IRQ_ENABLE, 32'h30);
    for (int i = 0; i < 3; i++) begin
      stretch <= (i == 0) ? 8'h00 : 8'h08;
      xfer(1'b1, `I2CM_OFF_RELOAD, {24'h0, rl[i]});
      rd(`I2CM_OFF_RELOAD, {24'h0, rl[i]});
      op(`I2CM_OFF_BUFFER, bt[i], 8'h10, 2'b10, 1'b1);
      chk({23'h0, sh}, {23'h0, bt[i], 1'b1});
      len[i] = last_run;
    end
    for (int i = 1; i < 3; i++) begin
      dd = len[i] - len[0] - 4 * (rl[i] - rl[0]);
      chk({31'h0, dd >= -3 && dd <= 3}, 32'h1);
    end
    // fast setting only for short runs, the bus far side tolerates it
    xfer(1'b1, `I2CM_OFF_RELOAD, 32'h04);
    rs(2'b00, 2'b00, 8'h10, 2'b11);
    xfer(1'b1, `I2CM_OFF_IRQ_ENABLE, 32'h20);
    op(`I2CM_OFF_CONTROL_TWO, 8'h04, 8'h10, 2'b00, 1'b0);
    xfer(1'b1, `I2CM_OFF_IRQ_ENABLE, 32'h30);
    pull <= 2'b01;
    op(`I2CM_OFF_CONTROL_TWO, 8'h14, 8'h20, 2'b00, 1'b1);
    @(posedge pclk);
    pull <= 2'b00;
    fork
      op(`I2CM_OFF_CONTROL_TWO, 8'h04, 8'h20, 2'b00, 1'b1);
      begin
        wait (lines_oe.sda === 1'b1);
        repeat (12) @(posedge pclk);
        pull <= 2'b10;
      end
    join
    @(posedge pclk);
    pull <= 2'b00;
    rs(2'b01, 2'b00, 8'h20, 2'b00);
    rs(2'b00, 2'b10, 8'h20, 2'b00);
    rs(2'b00, 2'b01, 8'h10, 2'b11);
    // another master holds data low while our released one-bit is clocked
    @(posedge pclk);
    pull <= 2'b01;
    op(`I2CM_OFF_BUFFER, 8'hff, 8'h20, 2'b00, 1'b1);
    final_report();
  end
endmodule

`default_nettype wire
